// >>> hdl/sac_pkg.sv
// package: register map, field layout, reset values and timing counts of the converter control
`default_nettype none
package sac_pkg;
   // =========================================================
   // register addresses
   localparam logic [7:0] ADDR_CTRL_ONE  = 8'hE8;
   localparam logic [7:0] ADDR_CTRL_TWO  = 8'hB2;
   localparam logic [7:0] ADDR_CONFIG    = 8'hBC;
   localparam logic [7:0] ADDR_RES_LOW   = 8'hBD;
   localparam logic [7:0] ADDR_RES_HIGH  = 8'hBE;
   localparam logic [7:0] ADDR_UPPER_LOW = 8'hC3;
   localparam logic [7:0] ADDR_UPPER_HI  = 8'hC4;
   localparam logic [7:0] ADDR_LOWER_LOW = 8'hC5;
   localparam logic [7:0] ADDR_LOWER_HI  = 8'hC6;
   // =========================================================
   // field positions
   localparam int BIT_ON      = 7;
   localparam int BIT_BURST   = 6;
   localparam int BIT_DONE    = 5;
   localparam int BIT_BUSY    = 4;
   localparam int BIT_WIN     = 3;
   localparam int BIT_CMBUF   = 0;
   localparam int BIT_EIGHT   = 2;
   localparam int BIT_TRACK   = 1;
   localparam int BIT_GAIN    = 0;
   // =========================================================
   // reset values
   localparam logic [7:0]  RST_CTRL_ONE = 8'h00;
   localparam logic [7:0]  RST_CTRL_TWO = 8'h00;
   localparam logic [7:0]  RST_CONFIG   = 8'hF8;
   localparam logic [15:0] RST_UPPER    = 16'hFFFF;
   localparam logic [15:0] RST_LOWER    = 16'h0000;
   // =========================================================
   // start sources
   localparam logic [2:0] SRC_SW   = 3'h0;
   localparam logic [2:0] SRC_T0   = 3'h1;
   localparam logic [2:0] SRC_T2   = 3'h2;
   localparam logic [2:0] SRC_T3   = 3'h3;
   localparam logic [2:0] SRC_EXT  = 3'h4;
   // =========================================================
   // timing
   localparam logic [2:0] TRACK_TICKS = 3'h4;
   localparam int         BURST_LEN   = 4;
   typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} sac_state_t;
endpackage : sac_pkg
`default_nettype wire

// >>> hdl/sac_core_if.sv
// interface: signals shared between the control core, the sar divider and the window check
`default_nettype none
interface sac_core_if;
   logic [15:0] sample;
   logic [15:0] upper_lim;
   logic [15:0] lower_lim;
   logic        win_hit;
   logic [4:0]  divider;
   logic        burst;
   logic        enable;
   logic        sar_tick;
   modport ctrl (output sample, upper_lim, lower_lim, divider, burst, enable,
                 input win_hit, sar_tick);
   modport win  (input sample, upper_lim, lower_lim, output win_hit);
   modport clkd (input divider, burst, enable, output sar_tick);
endinterface : sac_core_if
`default_nettype wire

// >>> hdl/sac_sar_divider.sv
// sar clock divider: one-cycle tick per (divider + 1) source ticks
`default_nettype none
module sac_sar_divider
   import sac_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic hfo_tick,
   sac_core_if.clkd  bus
);
   typedef struct packed {
      logic [4:0] cnt;
      logic       tick;
   } sac_div_t;
   sac_div_t q, next_q;
   logic     src_tick;

   // =========================================================
   // divider
   always_comb begin
      next_q      = q;
      next_q.tick = 1'b0;
      src_tick    = bus.burst ? hfo_tick : 1'b1;
      if (!bus.enable) begin
         next_q.cnt = 5'h00;
      end else if (src_tick) begin
         if (q.cnt >= bus.divider) begin
            next_q.cnt  = 5'h00;
            next_q.tick = 1'b1;
         end else begin
            next_q.cnt = q.cnt + 5'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign bus.sar_tick = q.tick;

   property p_div_quiet;
      @(posedge clk) disable iff (!rst_b) !bus.enable |=> !bus.sar_tick;
   endproperty
   a_div_quiet: assert property (p_div_quiet) else $error("sar tick while off");
endmodule : sac_sar_divider
`default_nettype wire

// >>> hdl/sac_window.sv
// window check of a conversion word against the two limits
`default_nettype none
module sac_window
   import sac_pkg::*;
(
   sac_core_if.win bus
);
   // lower limit above upper gives an inside window, otherwise an outside window
   function automatic logic in_window(input logic [15:0] r, input logic [15:0] up,
                                      input logic [15:0] lo);
      if (lo > up) begin
         in_window = (r > up) && (r < lo);
      end else begin
         in_window = (r > up) || (r < lo);
      end
   endfunction : in_window

   assign bus.win_hit = in_window(bus.sample, bus.upper_lim, bus.lower_lim);
endmodule : sac_window
`default_nettype wire

// >>> hdl/sac_control.sv
// converter control: registers, start source selection, track delay and burst sequencing
// =========================================================
// Operation
// - enable bit 0 powers the converter down, 1 makes it active
// - burst bit selects single conversions or a burst per trigger
// - done flag sets per conversion, or per whole burst in burst mode
// - done and window flags request interrupts; only software clears them
// - with source 000, writing 1 to busy starts a conversion or burst
// - window flag sets when the result lies within the limit window
// - source 001, 010, 011 start on timer 0, 2, 3 overflow
// - source 100 starts on each rising edge of the external pin
// - bit 0 of control two switches the common-mode buffer
// - limit order selects inside or outside window detection
// - track mode 1 delays conversion start by 4 sar clock cycles
// - eight-bit select and gain select drive the analog converter
`default_nettype none
module sac_control
   import sac_pkg::*;
#(
   parameter int BURST_COUNT = BURST_LEN
)(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic [7:0]  sfr_wdata,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   output logic      [7:0]  sfr_rdata,
   input  wire logic        timer0_ovf,
   input  wire logic        timer2_ovf,
   input  wire logic        timer3_ovf,
   input  wire logic        external_convert_pin,
   input  wire logic        hfo_tick,
   input  wire logic        conv_done,
   input  wire logic [15:0] conv_result,
   output logic             converter_on,
   output logic             conv_start,
   output logic             tracking,
   output logic             sar_tick,
   output logic             eight_bit_select,
   output logic             input_gain_select,
   output logic             common_mode_buffer_on,
   output logic             done_irq,
   output logic             window_irq
);
   typedef struct packed {
      logic        on;
      logic        burst;
      logic        done_f;
      logic        win_f;
      logic [2:0]  src;
      logic        cmbuf;
      logic [4:0]  div;
      logic        eightb;
      logic        trk_sel;
      logic        gain;
      logic [15:0] res;
      logic [15:0] upper;
      logic [15:0] lower;
      sac_state_t  st;
      logic [2:0]  tcnt;
      logic [7:0]  bcnt;
      logic        start;
      logic        trk;
      logic        ext_q;
      logic [7:0]  rdata;
   } sac_ctl_t;

   sac_ctl_t   q, next_q;
   sac_core_if cif ();
   logic       busy;
   logic       trig;
   logic       wr_one;
   logic [7:0] rd_val;

   // =========================================================
   // helpers
   sac_sar_divider u_div (
      .clk      (clk),
      .rst_b    (rst_b),
      .hfo_tick (hfo_tick),
      .bus      (cif.clkd)
   );

   sac_window u_win (
      .bus (cif.win)
   );

   assign cif.sample    = conv_result;
   assign cif.upper_lim = q.upper;
   assign cif.lower_lim = q.lower;
   assign cif.divider   = q.div;
   assign cif.burst     = q.burst;
   assign cif.enable    = q.on;
   assign busy          = (q.st != ST_IDLE);
   assign wr_one        = sfr_wr && (sfr_addr == ADDR_CTRL_ONE);

   // =========================================================
   // read mux
   always_comb begin
      case (sfr_addr)
         ADDR_CTRL_ONE:  rd_val = {q.on, q.burst, q.done_f, busy, q.win_f, q.src};
         ADDR_CTRL_TWO:  rd_val = {7'h00, q.cmbuf};
         ADDR_CONFIG:    rd_val = {q.div, q.eightb, q.trk_sel, q.gain};
         ADDR_RES_LOW:   rd_val = q.res[7:0];
         ADDR_RES_HIGH:  rd_val = q.res[15:8];
         ADDR_UPPER_LOW: rd_val = q.upper[7:0];
         ADDR_UPPER_HI:  rd_val = q.upper[15:8];
         ADDR_LOWER_LOW: rd_val = q.lower[7:0];
         ADDR_LOWER_HI:  rd_val = q.lower[15:8];
         default:        rd_val = 8'h00;
      endcase
   end

   // =========================================================
   // next state
   always_comb begin
      next_q       = q;
      next_q.start = 1'b0;
      next_q.ext_q = external_convert_pin;
      if (sfr_rd) begin
         next_q.rdata = rd_val;
      end
      if (sfr_wr) begin
         case (sfr_addr)
            ADDR_CTRL_ONE: begin
               next_q.on     = sfr_wdata[BIT_ON];
               next_q.burst  = sfr_wdata[BIT_BURST];
               next_q.done_f = sfr_wdata[BIT_DONE];
               next_q.win_f  = sfr_wdata[BIT_WIN];
               next_q.src    = sfr_wdata[2:0];
            end
            ADDR_CTRL_TWO:  next_q.cmbuf = sfr_wdata[BIT_CMBUF];
            ADDR_CONFIG: begin
               next_q.div     = sfr_wdata[7:3];
               next_q.eightb  = sfr_wdata[BIT_EIGHT];
               next_q.trk_sel = sfr_wdata[BIT_TRACK];
               next_q.gain    = sfr_wdata[BIT_GAIN];
            end
            ADDR_UPPER_LOW: next_q.upper[7:0]  = sfr_wdata;
            ADDR_UPPER_HI:  next_q.upper[15:8] = sfr_wdata;
            ADDR_LOWER_LOW: next_q.lower[7:0]  = sfr_wdata;
            ADDR_LOWER_HI:  next_q.lower[15:8] = sfr_wdata;
            default: ;
         endcase
      end
      // a source change takes effect with the same write, so no stale trigger slips in
      case (next_q.src)
         SRC_SW:  trig = wr_one && sfr_wdata[BIT_BUSY];
         SRC_T0:  trig = timer0_ovf;
         SRC_T2:  trig = timer2_ovf;
         SRC_T3:  trig = timer3_ovf;
         SRC_EXT: trig = external_convert_pin && !q.ext_q;
         default: trig = 1'b0;
      endcase
      trig = trig && next_q.on;
      case (q.st)
         ST_IDLE: begin
            next_q.bcnt = 8'h00;
            if (trig) begin
               next_q.tcnt = 3'h0;
               if (q.trk_sel) begin
                  next_q.st = ST_TRACK;
               end else begin
                  next_q.st    = ST_CONV;
                  next_q.start = 1'b1;
               end
            end
         end
         ST_TRACK: begin
            if (cif.sar_tick) begin
               next_q.tcnt = q.tcnt + 3'h1;
               if (q.tcnt == TRACK_TICKS - 3'h1) begin
                  next_q.st    = ST_CONV;
                  next_q.start = 1'b1;
               end
            end
         end
         ST_CONV: begin
            if (conv_done) begin
               next_q.res = conv_result;
               if (cif.win_hit) begin
                  next_q.win_f = 1'b1;
               end
               if (q.burst && (q.bcnt != 8'(BURST_COUNT - 1))) begin
                  next_q.bcnt = q.bcnt + 8'h01;
                  next_q.tcnt = 3'h0;
                  if (q.trk_sel) begin
                     next_q.st = ST_TRACK;
                  end else begin
                     next_q.start = 1'b1;
                  end
               end else begin
                  next_q.done_f = 1'b1;
                  next_q.st     = ST_IDLE;
               end
            end
         end
         default: next_q.st = ST_IDLE;
      endcase
      if (!next_q.on) begin
         next_q.st    = ST_IDLE;
         next_q.start = 1'b0;
      end
      next_q.trk = (next_q.st == ST_TRACK);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q         <= '0;
         q.div     <= RST_CONFIG[7:3];
         q.upper   <= RST_UPPER;
         q.lower   <= RST_LOWER;
         q.st      <= ST_IDLE;
      end else begin
         q <= next_q;
      end
   end

   // =========================================================
   // outputs
   assign sfr_rdata             = q.rdata;
   assign converter_on          = q.on;
   assign conv_start            = q.start;
   assign tracking              = q.trk;
   assign sar_tick              = cif.sar_tick;
   assign eight_bit_select      = q.eightb;
   assign input_gain_select     = q.gain;
   assign common_mode_buffer_on = q.cmbuf;
   assign done_irq              = q.done_f;
   assign window_irq            = q.win_f;

   // =========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_track_start;
      q.st == ST_IDLE && q.on && trig && q.trk_sel;
   endsequence
   // a slow sar clock stretches the track phase far beyond what one sequence may span,
   // so the phase is checked step by step: entry, hold between ticks, and tick count at exit
   sequence s_track_end;
      conv_start && $past(tracking);
   endsequence

   property p_off_idle;
      !q.on |-> !busy && !conv_start;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("active while off");
   property p_single_done;
      q.st == ST_CONV && conv_done && !q.burst && q.on |=> done_irq;
   endproperty
   a_single_done: assert property (p_single_done) else $error("done flag missed");
   property p_burst_hold;
      q.st == ST_CONV && conv_done && q.burst && q.bcnt == 8'h00 && !wr_one
         |=> !$rose(done_irq);
   endproperty
   a_burst_hold: assert property (p_burst_hold) else $error("early burst flag");
   property p_flag_sticky;
      done_irq && !wr_one |=> done_irq;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("hw cleared flag");
   property p_sw_start;
      q.st == ST_IDLE && q.on && wr_one && sfr_wdata[BIT_BUSY] && sfr_wdata[BIT_ON]
         && sfr_wdata[2:0] == SRC_SW && !q.trk_sel |=> conv_start && busy;
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("sw start lost");
   property p_window;
      q.st == ST_CONV && conv_done && cif.win_hit && q.on |=> window_irq;
   endproperty
   a_window: assert property (p_window) else $error("window flag missed");
   property p_timer;
      q.st == ST_IDLE && q.on && !sfr_wr && q.src == SRC_T2 && timer2_ovf && !q.trk_sel
         |=> conv_start;
   endproperty
   a_timer: assert property (p_timer) else $error("timer start lost");
   property p_ext_edge;
      q.st == ST_IDLE && q.on && !sfr_wr && q.src == SRC_EXT && !q.trk_sel
         && external_convert_pin && !q.ext_q |=> conv_start;
   endproperty
   a_ext_edge: assert property (p_ext_edge) else $error("pin edge lost");
   property p_reserved;
      q.st == ST_IDLE && !sfr_wr && q.src > SRC_EXT |=> !conv_start && !busy;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved source ran");
   property p_track;
      s_track_start |=> tracking && !conv_start;
   endproperty
   a_track: assert property (p_track) else $error("track phase missed");
   property p_track_hold;
      tracking && !sar_tick && !wr_one |=> tracking && !conv_start;
   endproperty
   a_track_hold: assert property (p_track_hold) else $error("track left early");
   property p_track_len;
      s_track_end |-> q.tcnt == TRACK_TICKS;
   endproperty
   a_track_len: assert property (p_track_len) else $error("track delay wrong");
   property p_cmbuf;
      sfr_wr && sfr_addr == ADDR_CTRL_TWO |=> common_mode_buffer_on == $past(sfr_wdata[0]);
   endproperty
   a_cmbuf: assert property (p_cmbuf) else $error("buffer bit wrong");
endmodule : sac_control
`default_nettype wire

// >>> sim/sac_adc_model.sv
// analog converter model: answers each start pulse with a done pulse and a result word
`default_nettype none
module sac_adc_model #(
   parameter int LAT = 5
)(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        conv_start,
   input  wire logic [15:0] res_in,
   output logic             conv_done,
   output logic      [15:0] conv_result
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   // =========================================================
   // conversion timing
   // result is only valid with done; otherwise it flips every cycle so no stale value is trusted
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
         conv_done <= 1'b0;
         conv_result <= 16'h0000;
      end else begin
         conv_done <= (cnt == 1);
         conv_result <= (cnt == 1) ? res_in : ~conv_result;
         cnt <= conv_start ? LAT : ((cnt > 0) ? cnt - 1 : 0);
      end
   end
endmodule : sac_adc_model
`default_nettype wire

// >>> sim/sar_adc_control_regs_tb_top.sv
// testbench: register map, start sources, flags, burst and track delay of the converter control
`default_nettype none
module sar_adc_control_regs_tb_top
   import sac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} sac_row_t;
   logic clk = 0, rst_b = 0, wr = 0, rd = 0, t0 = 0, t2 = 0, t3 = 0, pin = 0, hfo = 0;
   logic [7:0] addr = 0, wdata = 0, rdata, got;
   logic [15:0] res_in = 0, conv_result;
   logic conv_done, on, start, trk, tick, e8, gn, cmb, dirq, wirq;
   int n_mismatch = 0, checks_done = 0, cycles = 0;
   int n_starts = 0, n_ticks = 0, trk_ticks = 0, trk_last = 0, n0, i, k;
   sac_row_t rows[7] = '{
      '{ADDR_CTRL_TWO, 8'h01, 8'h01},
      '{8'h00, 8'h55, 8'h00},
      '{ADDR_UPPER_LOW, 8'h40, 8'h40},
      '{ADDR_UPPER_HI, 8'h00, 8'h00},
      '{ADDR_LOWER_LOW, 8'h80, 8'h80},
      '{ADDR_LOWER_HI, 8'h00, 8'h00},
      '{ADDR_CONFIG, 8'h07, 8'h07}};
   logic [15:0] res_tab[6] = '{16'h0041, 16'h0080, 16'h0040, 16'h007F, 16'h0081, 16'h0060};
   logic        win_tab[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   always #12.5 clk = ~clk;
   always @(posedge clk) hfo <= #1 ~hfo;
   sac_control #(.BURST_COUNT(3)) sac_control_inst (
      .clk(clk), .rst_b(rst_b), .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(wr), .sfr_rd(rd),
      .sfr_rdata(rdata), .timer0_ovf(t0), .timer2_ovf(t2), .timer3_ovf(t3),
      .external_convert_pin(pin), .hfo_tick(hfo), .conv_done(conv_done),
      .conv_result(conv_result), .converter_on(on), .conv_start(start), .tracking(trk),
      .sar_tick(tick), .eight_bit_select(e8), .input_gain_select(gn),
      .common_mode_buffer_on(cmb), .done_irq(dirq), .window_irq(wirq));
   sac_adc_model sac_adc_model_inst (
      .clk(clk), .rst_b(rst_b), .conv_start(start), .res_in(res_in),
      .conv_done(conv_done), .conv_result(conv_result));
   // =========================================================
   // monitors and timeout
   always @(posedge clk) begin
      if (start === 1'b1) n_starts++;
      if (start === 1'b1) trk_last = trk_ticks;
      if (start === 1'b1) trk_ticks = 0;
      else if (trk === 1'b1 && tick === 1'b1) trk_ticks++;
      if (tick === 1'b1) n_ticks++;
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   // =========================================================
   // tasks
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk8
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 {wr, addr, wdata} = {1'b1, a, d};
      @(posedge clk);
      #1 wr = 0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a);
      @(posedge clk);
      #1 {rd, addr} = {1'b1, a};
      @(posedge clk);
      #1 rd = 0;
      got = rdata;
   endtask : rreg
   task automatic trig(input int s);
      @(posedge clk);
      #1 {t0, t2, t3, pin} = {s == 1, s == 2, s == 3, s == 4};
      @(posedge clk);
      #1 {t0, t2, t3} = 3'h0;
      repeat (2) @(posedge clk);
      #1 pin = 0;
   endtask : trig
   task automatic wait_done();
      for (int j = 0; j < 200 && dirq !== 1'b1; j++) begin
         @(posedge clk);
         #1;
      end
   endtask : wait_done
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   // =========================================================
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      #1 rst_b = 1;
      chk8("outs", 8'h00, {on, trk, tick, e8, gn, cmb, dirq, wirq});
      rreg(ADDR_CONFIG);
      chk8("config", RST_CONFIG, got);
      rreg(ADDR_CTRL_ONE);
      chk8("ctrl one", RST_CTRL_ONE, got);
      foreach (rows[r]) begin
         wreg(rows[r].a, rows[r].d);
         rreg(rows[r].a);
         chk8("row read", rows[r].e, got);
      end
      chk8("pins", 8'h07, {5'h0, e8, gn, cmb});
      wreg(ADDR_CONFIG, 8'h00);
      // software start with results at and around the window edges
      for (i = 0; i < 6; i++) begin
         // swapped limits for the last two rows turn the window inside out
         if (i == 4) begin
            wreg(ADDR_UPPER_LOW, 8'h80);
            wreg(ADDR_LOWER_LOW, 8'h40);
         end
         res_in = res_tab[i];
         n0 = n_starts;
         wreg(ADDR_CTRL_ONE, 8'h90);
         wait_done();
         chk8("done", 8'h01, {7'h0, dirq});
         chk8("window", {7'h0, win_tab[i]}, {7'h0, wirq});
         chk8("starts", 8'(n0 + 1), 8'(n_starts));
         repeat (10) @(posedge clk);
         rreg(ADDR_CTRL_ONE);
         chk8("ctrl one", {3'h5, 1'b0, win_tab[i], 3'h0}, got);
         rreg(ADDR_RES_LOW);
         chk8("result", res_tab[i][7:0], got);
      end
      wreg(ADDR_CTRL_ONE, 8'h80);
      chk8("irqs", 8'h00, {6'h0, dirq, wirq});
      // each timer or pin source, with a foreign source tried first
      for (k = 1; k <= 4; k++) begin
         wreg(ADDR_CTRL_ONE, 8'h80 | 8'(k));
         n0 = n_starts;
         trig((k % 4) + 1);
         chk8("foreign", 8'(n0), 8'(n_starts));
         trig(k);
         wait_done();
         chk8("source", 8'(n0 + 1), 8'(n_starts));
      end
      // reserved source drops every trigger; a disabled converter drops a software start
      n0 = n_starts;
      wreg(ADDR_CTRL_ONE, 8'h85);
      for (k = 1; k <= 4; k++) trig(k);
      wreg(ADDR_CTRL_ONE, 8'h95);
      wreg(ADDR_CTRL_ONE, 8'h10);
      trig(1);
      repeat (10) @(posedge clk);
      chk8("ignored", 8'(n0), 8'(n_starts));
      chk8("off", 8'h00, {7'h0, on});
      // burst of three conversions sets done only at its end
      n0 = n_starts;
      wreg(ADDR_CTRL_ONE, 8'hD0);
      for (i = 0; i < 200 && n_starts < n0 + 2; i++) @(posedge clk);
      #1 chk8("mid burst", 8'h00, {7'h0, dirq});
      wait_done();
      chk8("burst", 8'(n0 + 3), 8'(n_starts));
      // sar clock division and delayed tracking
      wreg(ADDR_CONFIG, 8'h0A);
      wreg(ADDR_CTRL_ONE, 8'h80);
      n_ticks = 0;
      repeat (20) @(posedge clk);
      #1 chk8("ticks", 8'h0A, 8'(n_ticks));
      wreg(ADDR_CTRL_ONE, 8'h90);
      wait_done();
      chk8("track ticks", 8'h04, 8'(trk_last));
      wreg(ADDR_CTRL_ONE, 8'hC0);
      n_ticks = 0;
      repeat (20) @(posedge clk);
      #1 chk8("burst ticks", 8'h05, 8'(n_ticks));
      // reset in mid run, with the converter on and the buffer set, returns all to rest
      rst_b = 0;
      repeat (2) @(posedge clk);
      #1 rst_b = 1;
      chk8("reset outs", 8'h00, {on, trk, tick, e8, gn, cmb, dirq, wirq});
      rreg(ADDR_CONFIG);
      chk8("reset config", RST_CONFIG, got);
      rreg(ADDR_CTRL_TWO);
      chk8("reset ctrl two", RST_CTRL_TWO, got);
      wrap_up();
   end
endmodule : sar_adc_control_regs_tb_top
`default_nettype wire
